// *** logic/swd_pkg.sv ***
// swd_pkg: constants, register layout and state codes of the watchdog.
// assumes a 10 MHz core clock; all timer tables are held in microseconds.
package swd_pkg;

    // clock and timer base
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TICK_NS = 1000;
    localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W = 4;
    localparam int unsigned CNT_W = 28;

    // register offsets on the internal register port
    localparam logic [7:0] ADDR_MODE = 8'h4d;
    localparam logic [7:0] ADDR_CFG = 8'h55;

    // mode register layout; bits [7:4] are not used and read zero
    localparam int unsigned MODE_USED_W = 4;
    localparam int unsigned MODE_INDEP_BIT = 3;
    localparam logic [7:0] MODE_RESET = 8'h01;

    // configuration register layout
    localparam int unsigned CFG_TMO_LSB = 0;
    localparam int unsigned CFG_TMO_W = 3;
    localparam int unsigned CFG_STARTUP_LSB = 3;
    localparam int unsigned CFG_STARTUP_W = 2;
    localparam int unsigned CFG_WD_EN_BIT = 5;
    localparam int unsigned CFG_STARTUP_EN_BIT = 6;
    localparam int unsigned CFG_RST_OUT_EN_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // timer tables, microseconds
    localparam int unsigned KICK_TMO_US [8] = '{
        1500, 6000, 18750, 75000, 300000, 1200000, 2400000, 4800000};
    localparam int unsigned STARTUP_US [4] = '{
        38400000, 76800000, 153600000, 192000000};
    localparam int unsigned RST_TMO_US [8] = '{
        25, 3000, 37500, 150000, 300000, 600000, 1200000, 2400000};

    // fault pulse on expiry with reset output enabled
    localparam int unsigned FAULT_PULSE_CYC = 3;
    localparam int unsigned RST_REQ_PHASE = 1;
    localparam int unsigned PULSE_W = 2;

    // pin synchroniser reset image: {undervoltage_lockout_ok, manual_reset_n, enable, kick}
    localparam int unsigned PIN_W = 4;
    localparam logic [3:0] PIN_INIT = 4'h4;
    localparam int unsigned PIN_KICK = 0;
    localparam int unsigned PIN_EN = 1;
    localparam int unsigned PIN_MR_N = 2;
    localparam int unsigned PIN_UNDERVOLTAGE_LOCKOUT = 3;

    typedef enum logic [2:0] {
        SWD_OFF = 3'b000,
        SWD_STARTUP = 3'b001,
        SWD_RUN = 3'b010,
        SWD_FAULT = 3'b011,
        SWD_PULSE = 3'b100
    } swd_wd_state_t;

endpackage

// *** logic/swd_sync_edge.sv ***
// swd_sync_edge: two-flop synchroniser with a third stage for edge detect.
// assumes inputs are asynchronous to clk_i; reset is asynchronous, active low.
`timescale 1ns/1ps
module swd_sync_edge #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] toggle_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } swd_sync_t;

    swd_sync_t st;
    swd_sync_t next_st;

    if (WIDTH < 1) begin : g_chk
        $error("swd_sync_edge: WIDTH must be at least 1");
    end

    // meta feeds only the sync stage, never any logic
    always_comb begin
        next_st = st;
        next_st.meta = async_i;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= {INIT, INIT, INIT};
        end else begin
            st <= next_st;
        end
    end

    // either edge counts once per level change
    assign level_o = st.sync;
    assign toggle_o = st.sync ^ st.prev; // RULE_20

endmodule

// *** logic/swd_watchdog.sv ***
// swd_watchdog: processor watchdog with system reset generator.
// assumes sequencer, boot and reboot signals come from core_clk_i logic;
// kick, enable, manual reset and lockout inputs are asynchronous pins.
//
// Notes on behaviour
// [RULE_01] mode bit 0 selects dependent, 1 selects independent operation.
// [RULE_02] dependent: idle until sequencing done and system reset released.
// [RULE_03] independent: start once supply above lockout and boot finished.
// [RULE_04] independent: sequencer reset leaves counter and fault untouched.
// [RULE_05] startup delay enable bit chooses long startup period or none.
// [RULE_06] startup delay follows every reset event once sequencing done; in independent mode sequencer, manual and soft reboot resets do not restart it.
// [RULE_07] two-bit field picks 38.4, 76.8, 153.6 or 192 s startup.
// [RULE_08] three-bit field picks kick timeout from 1.5 ms to 4800 ms.
// [RULE_09] first kick during startup switches to normal timeout.
// [RULE_10] processor must toggle kick within every timeout, else fault.
// [RULE_11] fault stays until kick toggles or system reset asserts; in independent mode sequencer, manual and soft reboot resets leave it set.
// [RULE_12] counter held in reset while enable input is low.
// [RULE_13] watchdog enable bit turns supervision on or off.
// [RULE_14] dependent: system reset clears counter and fault while held.
// [RULE_15] reset output enable: expiry pulses system reset for timeout.
// [RULE_16] with reset output enable, fault low three clocks on expiry.
// [RULE_17] independent expiry order: fault, then reset, then fault off.
// [RULE_18] independent without reset enable: expiry sets fault only.
// [RULE_19] system reset held at power-up, released after reset timeout.
// [RULE_20] kick synchronised, each level change is one transition.
`timescale 1ns/1ps
module swd_watchdog #(
    parameter int unsigned TICK_CYC = swd_pkg::TICK_CYC,
    parameter int unsigned KICK_TMO_US [8] = swd_pkg::KICK_TMO_US,
    parameter int unsigned STARTUP_US [4] = swd_pkg::STARTUP_US,
    parameter int unsigned RST_TMO_US [8] = swd_pkg::RST_TMO_US
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // internal register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // pins
    input wire logic kick_input_i,
    input wire logic enable_pin_i,
    input wire logic manual_reset_input_n_i,
    input wire logic undervoltage_lockout_ok_i,
    // system logic on core_clk_i
    input wire logic boot_done_i,
    input wire logic seq_done_i,
    input wire logic seq_reset_req_i,
    input wire logic soft_reboot_i,
    input wire logic [2:0] reset_timeout_sel_i,
    // outputs
    output logic watchdog_fault_output_n_o,
    output logic system_reset_n_o,
    output logic [2:0] wd_state_o
);

    localparam int unsigned CNT_W = swd_pkg::CNT_W;
    localparam int unsigned TICK_W = swd_pkg::TICK_W;
    localparam int unsigned CNT_MAX = (1 << CNT_W) - 1;

    typedef struct packed {
        logic [7:0] mode_reg;
        logic [7:0] cfg_reg;
        logic [7:0] rdata;
        swd_pkg::swd_wd_state_t wd_state;
        logic [CNT_W-1:0] wd_cnt;
        logic [TICK_W-1:0] tick_cnt;
        logic [swd_pkg::PULSE_W-1:0] pulse_cnt;
        logic fault_n;
        logic rst_asserted;
        logic [CNT_W-1:0] rst_cnt;
    } swd_state_t;

    swd_state_t st;
    swd_state_t next_st;

    logic rst_n;
    logic [swd_pkg::PIN_W-1:0] pin_lvl;
    logic [swd_pkg::PIN_W-1:0] pin_tgl;
    logic kick_edge;
    logic tick;
    logic wd_on;
    logic gate;
    logic indep;
    logic rst_hold;
    logic rst_req;
    logic expire;

    // elaboration checks on the shortening parameters
    if (TICK_CYC < 1 || TICK_CYC > (1 << TICK_W)) begin : g_chk_tick
        $error("swd_watchdog: TICK_CYC out of range");
    end
    for (genvar i = 0; i < 8; i++) begin : g_chk_kick
        if (KICK_TMO_US[i] < 1 || KICK_TMO_US[i] > CNT_MAX ||
            RST_TMO_US[i] < 1 || RST_TMO_US[i] > CNT_MAX) begin : g_bad
            $error("swd_watchdog: timeout table entry out of range");
        end
    end
    for (genvar i = 0; i < 4; i++) begin : g_chk_start
        if (STARTUP_US[i] < 1 || STARTUP_US[i] > CNT_MAX) begin : g_bad
            $error("swd_watchdog: startup table entry out of range");
        end
    end

    // microseconds to tick load value; counter expires one tick after zero
    function automatic logic [CNT_W-1:0] us_to_load(input int unsigned us);
        logic [63:0] ticks;
        ticks = (64'(us) * 64'd1000) / 64'(swd_pkg::TICK_NS);
        return CNT_W'(ticks - 64'd1);
    endfunction

    function automatic logic [CNT_W-1:0] kick_load(input logic [7:0] cfg);
        logic [2:0] sel;
        sel = cfg[swd_pkg::CFG_TMO_LSB +: swd_pkg::CFG_TMO_W];
        return us_to_load(KICK_TMO_US[sel]); // RULE_08
    endfunction

    function automatic logic [CNT_W-1:0] start_load(input logic [7:0] cfg);
        logic [1:0] sel;
        sel = cfg[swd_pkg::CFG_STARTUP_LSB +: swd_pkg::CFG_STARTUP_W];
        return us_to_load(STARTUP_US[sel]); // RULE_07
    endfunction

    // entry after any restart: long startup only when enabled
    function automatic swd_pkg::swd_wd_state_t entry_state(
        input logic [7:0] cfg);
        if (cfg[swd_pkg::CFG_STARTUP_EN_BIT]) begin // RULE_05
            return swd_pkg::SWD_STARTUP;
        end
        return swd_pkg::SWD_RUN;
    endfunction

    function automatic logic [CNT_W-1:0] entry_load(input logic [7:0] cfg);
        if (cfg[swd_pkg::CFG_STARTUP_EN_BIT]) begin
            return start_load(cfg);
        end
        return kick_load(cfg);
    endfunction

    // reset release through two flops
    swd_sync_edge #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_rst_sync (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(1'b1),
        .level_o(rst_n),
        .toggle_o()
    );

    // all pin inputs share one synchroniser bank
    swd_sync_edge #(
        .WIDTH(swd_pkg::PIN_W),
        .INIT(swd_pkg::PIN_INIT)
    ) u_pin_sync (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .async_i({undervoltage_lockout_ok_i, manual_reset_input_n_i,
                  enable_pin_i, kick_input_i}),
        .level_o(pin_lvl),
        .toggle_o(pin_tgl)
    );

    // activation gating for both modes
    always_comb begin
        kick_edge = pin_tgl[swd_pkg::PIN_KICK]; // RULE_20
        tick = (st.tick_cnt == TICK_W'(TICK_CYC - 1));
        indep = st.mode_reg[swd_pkg::MODE_INDEP_BIT]; // RULE_01
        wd_on = st.cfg_reg[swd_pkg::CFG_WD_EN_BIT] && // RULE_13
                pin_lvl[swd_pkg::PIN_EN]; // RULE_12
        if (indep) begin
            // sequencer reset deliberately not looked at here
            gate = wd_on && pin_lvl[swd_pkg::PIN_UNDERVOLTAGE_LOCKOUT] && // RULE_03
                   boot_done_i; // RULE_04
        end else begin
            gate = wd_on && seq_done_i && !st.rst_asserted; // RULE_02 RULE_14
        end
        rst_hold = !pin_lvl[swd_pkg::PIN_UNDERVOLTAGE_LOCKOUT] || !seq_done_i ||
                   seq_reset_req_i || !pin_lvl[swd_pkg::PIN_MR_N] ||
                   !pin_lvl[swd_pkg::PIN_EN];
        rst_req = (st.wd_state == swd_pkg::SWD_PULSE) &&
                  (st.pulse_cnt ==
                   swd_pkg::PULSE_W'(swd_pkg::RST_REQ_PHASE)); // RULE_15
        expire = tick && (st.wd_cnt == '0);
    end

    // next state of registers, watchdog and reset generator
    always_comb begin
        next_st = st;

        // register writes; unused mode bits stay zero
        if (reg_wr_i && reg_addr_i == swd_pkg::ADDR_MODE) begin
            next_st.mode_reg = {4'h0, reg_wdata_i[swd_pkg::MODE_USED_W-1:0]};
        end
        if (reg_wr_i && reg_addr_i == swd_pkg::ADDR_CFG) begin
            next_st.cfg_reg = reg_wdata_i;
        end
        // registered read; unmapped offsets read zero
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                swd_pkg::ADDR_MODE: next_st.rdata = st.mode_reg;
                swd_pkg::ADDR_CFG: next_st.rdata = st.cfg_reg;
                default: next_st.rdata = 8'h00;
            endcase
        end

        // free-running prescaler; costs up to one tick of jitter on reload
        next_st.tick_cnt = tick ? '0 : st.tick_cnt + TICK_W'(1);

        if (!gate) begin
            // cleared and held while inactive, in system reset (dependent mode only) or disabled
            next_st.wd_state = swd_pkg::SWD_OFF; // RULE_12 RULE_14
            next_st.wd_cnt = '0;
            next_st.fault_n = 1'b1; // RULE_14
            next_st.pulse_cnt = '0;
        end else begin
            unique case (st.wd_state)
                swd_pkg::SWD_OFF: begin
                    // every restart after gate was low passes here, so startup follows it
                    next_st.wd_state = entry_state(st.cfg_reg); // RULE_06
                    next_st.wd_cnt = entry_load(st.cfg_reg);
                end
                swd_pkg::SWD_STARTUP, swd_pkg::SWD_RUN: begin
                    if (kick_edge) begin
                        next_st.wd_state = swd_pkg::SWD_RUN; // RULE_09
                        next_st.wd_cnt = kick_load(st.cfg_reg); // RULE_10
                    end else if (expire) begin
                        next_st.fault_n = 1'b0; // RULE_10
                        next_st.pulse_cnt = '0;
                        if (st.cfg_reg[swd_pkg::CFG_RST_OUT_EN_BIT]) begin
                            next_st.wd_state = swd_pkg::SWD_PULSE; // RULE_16
                        end else begin
                            next_st.wd_state = swd_pkg::SWD_FAULT; // RULE_18
                        end
                    end else if (tick) begin
                        next_st.wd_cnt = st.wd_cnt - CNT_W'(1);
                    end
                end
                swd_pkg::SWD_FAULT: begin
                    // only a kick ends it; in dependent mode system reset acts through gate
                    if (kick_edge) begin
                        next_st.fault_n = 1'b1; // RULE_11
                        next_st.wd_state = swd_pkg::SWD_RUN;
                        next_st.wd_cnt = kick_load(st.cfg_reg);
                    end
                end
                swd_pkg::SWD_PULSE: begin
                    // fault low, reset asserted mid-pulse, then fault off
                    next_st.pulse_cnt = st.pulse_cnt + swd_pkg::PULSE_W'(1);
                    if (st.pulse_cnt == swd_pkg::PULSE_W'(
                            swd_pkg::FAULT_PULSE_CYC - 1)) begin
                        next_st.fault_n = 1'b1; // RULE_16 RULE_17
                        next_st.pulse_cnt = '0;
                        // watchdog reset is itself a reset event
                        next_st.wd_state = entry_state(st.cfg_reg); // RULE_06
                        next_st.wd_cnt = entry_load(st.cfg_reg);
                    end
                end
                default: begin
                    next_st.wd_state = swd_pkg::SWD_OFF;
                    next_st.wd_cnt = '0;
                    next_st.fault_n = 1'b1;
                end
            endcase
        end

        // system reset: held by causes, then stretched by the timeout
        if (rst_hold || rst_req || soft_reboot_i) begin
            next_st.rst_asserted = 1'b1; // RULE_19 RULE_15
            next_st.rst_cnt = us_to_load(RST_TMO_US[reset_timeout_sel_i]);
        end else if (st.rst_asserted && tick) begin
            if (st.rst_cnt == '0) begin
                next_st.rst_asserted = 1'b0; // RULE_19
            end else begin
                next_st.rst_cnt = st.rst_cnt - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{
                mode_reg: swd_pkg::MODE_RESET,
                cfg_reg: swd_pkg::CFG_RESET,
                rdata: 8'h00,
                wd_state: swd_pkg::SWD_OFF,
                wd_cnt: '0,
                tick_cnt: '0,
                pulse_cnt: '0,
                fault_n: 1'b1,
                rst_asserted: 1'b1,
                rst_cnt: '0
            };
        end else begin
            st <= next_st;
        end
    end

    // every output straight from a flop
    assign reg_rdata_o = st.rdata;
    assign watchdog_fault_output_n_o = st.fault_n;
    assign system_reset_n_o = !st.rst_asserted;
    assign wd_state_o = st.wd_state;

endmodule

// *** tb/swd_watchdog_sva.sv ***
// swd_watchdog_sva: port-level checks of the watchdog and reset outputs.
// assumes the bench changes inputs just after the rising edge.
`timescale 1ns/1ps
module swd_watchdog_sva (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic kick_input_i,
    input wire logic enable_pin_i,
    input wire logic seq_reset_req_i,
    input wire logic watchdog_fault_output_n_o,
    input wire logic system_reset_n_o,
    input wire logic [2:0] wd_state_o
);
    logic [7:0] cfg;
    logic ind;
    logic [3:0] kh;
    logic fn, rn, quiet;
    assign fn = watchdog_fault_output_n_o;
    assign rn = system_reset_n_o;
    // kick pin unchanged long enough that no edge is still in flight
    assign quiet = (kh == {4{kick_input_i}});
    // shadow of written settings, same edge as the real registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg <= 8'h00;
            ind <= 1'b0;
            kh <= 4'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == swd_pkg::ADDR_CFG)
                cfg <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == swd_pkg::ADDR_MODE)
                ind <= reg_wdata_i[3];
            kh <= {kh[2:0], kick_input_i};
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_pulse3;
        $fell(fn) && cfg[7] |-> !fn [*3] ##1 fn;
    endproperty
    a_pulse3: assert property (p_pulse3)
        else $error("fault pulse not three cycles");
    property p_order;
        $fell(fn) && cfg[7] |-> rn ##2 !rn;
    endproperty
    a_order: assert property (p_order)
        else $error("reset did not follow fault");
    property p_rst_only;
        $fell(fn) && !cfg[7] && ind && rn && !seq_reset_req_i |=> rn [*4];
    endproperty
    a_rst_only: assert property (p_rst_only)
        else $error("expiry touched system reset");
    property p_hold;
        !fn && !cfg[7] && quiet && !reg_wr_i && !$past(reg_wr_i)
            |=> !fn || !rn;
    endproperty
    a_hold: assert property (p_hold)
        else $error("fault released without kick");
    property p_dep_clear;
        !ind && !rn && !$past(rn) |-> fn && wd_state_o == 3'h0;
    endproperty
    a_dep_clear: assert property (p_dep_clear)
        else $error("dependent watchdog active in reset");
    property p_indep_keep;
        ind && $rose(seq_reset_req_i) && wd_state_o == 3'h2
            |=> (wd_state_o != 3'h0) [*4];
    endproperty
    a_indep_keep: assert property (p_indep_keep)
        else $error("sequencer reset stopped watchdog");
    property p_en_pin;
        $fell(enable_pin_i) |-> ##[1:6] wd_state_o == 3'h0;
    endproperty
    a_en_pin: assert property (p_en_pin)
        else $error("enable low did not stop watchdog");
    property p_wd_off;
        reg_wr_i && reg_addr_i == swd_pkg::ADDR_CFG && !reg_wdata_i[5]
            |-> ##[1:3] wd_state_o == 3'h0;
    endproperty
    a_wd_off: assert property (p_wd_off)
        else $error("watchdog not off after disable");
    property p_startup;
        $past(wd_state_o) == 3'h0 && wd_state_o != 3'h0
            |-> wd_state_o == (cfg[6] ? 3'h1 : 3'h2);
    endproperty
    a_startup: assert property (p_startup)
        else $error("wrong first watchdog state");
    c_pulse: cover property ($fell(fn) && cfg[7]);
    c_long: cover property ($fell(fn) && !cfg[7]);
    c_run: cover property (wd_state_o == 3'h1 ##1 wd_state_o == 3'h2);
endmodule
bind swd_watchdog swd_watchdog_sva i_swd_watchdog_sva (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .kick_input_i(kick_input_i), .enable_pin_i(enable_pin_i),
    .seq_reset_req_i(seq_reset_req_i),
    .watchdog_fault_output_n_o(watchdog_fault_output_n_o),
    .system_reset_n_o(system_reset_n_o), .wd_state_o(wd_state_o));

// *** tb/swd_kick_proc.sv ***
// swd_kick_proc: supervised processor that toggles the kick pin.
// assumes run_i comes from the bench; pin changes off the clock edge.
`timescale 1ns/1ps
module swd_kick_proc (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [7:0] half_i,
    output logic kick_o
);
    logic [7:0] cnt = 8'h00;
    initial kick_o = 1'b0;
    // either edge counts, so a plain level toggle is a kick
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt <= 8'h00;
        end else if (cnt == half_i) begin
            cnt <= 8'h00;
            kick_o <= #37 ~kick_o;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// *** tb/tb.sv ***
// tb: self-checking bench for swd_watchdog with a kicking processor.
// assumes shortened timer tables and a two-clock tick.
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, wr, rd, krun, en, seq_rst, kick, fault_n, sysrst_n;
    logic [7:0] addr, wdata, rdata, code;
    logic [2:0] rsel, state;
    logic [7:0] rd_q[$];
    logic [1:0] ev_q[$];
    logic rd_seen, rst_seen;
    // system-side inputs driven by the bench so they can be exercised
    logic mr_n, undervoltage_lockout, boot, sdone, sreboot;
    int bad_count, total_checks, low_len;

    swd_watchdog #(.TICK_CYC(2),
        .KICK_TMO_US('{20, 24, 28, 32, 36, 40, 44, 48}),
        .STARTUP_US('{80, 90, 100, 110}),
        .RST_TMO_US('{4, 5, 6, 7, 8, 9, 10, 11})) i_swd_watchdog (
        .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .kick_input_i(kick), .enable_pin_i(en), .manual_reset_input_n_i(mr_n),
        .undervoltage_lockout_ok_i(undervoltage_lockout), .boot_done_i(boot),
        .seq_done_i(sdone), .seq_reset_req_i(seq_rst), .soft_reboot_i(sreboot),
        .reset_timeout_sel_i(rsel), .watchdog_fault_output_n_o(fault_n),
        .system_reset_n_o(sysrst_n), .wd_state_o(state));
    swd_kick_proc i_swd_kick_proc (.clk_i(clk), .run_i(krun),
        .half_i(8'h14), .kick_o(kick));

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] got);
        total_checks++;
        if (got !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // bounded wait on reset (use_rst) or fault output level
    task automatic wait_for(input logic use_rst, input logic v);
        int n;
        n = 0;
        while (((use_rst ? sysrst_n : fault_n) !== v) && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) begin
            bad_count++;
            $display("CHECK FAILED wait expected %h seen timeout", v);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // monitor: read data one edge after strobe; fault width and reset
    always @(posedge clk) begin
        rd_seen <= rd;
        if (rd_seen) chk("read data", rd_q.pop_front(), rdata);
        if (!fault_n) begin
            low_len <= low_len + 1;
            rst_seen <= rst_seen | !sysrst_n;
        end else if (low_len != 0) begin
            chk("fault event", {6'h0, ev_q.pop_front()},
                {6'h0, low_len == 3, rst_seen});
            low_len <= 0;
            rst_seen <= 1'b0;
        end
    end
    // hang guard, well beyond the roughly 1200 cycles of the run
    initial begin
        #(20000 * 100);
        bad_count++;
        give_verdict();
    end
    initial begin
        rsel = 3'($urandom(32'ha9e5dc6e));
        {rst_n, wr, rd, krun, seq_rst, rd_seen, rst_seen} = 7'h00;
        {addr, wdata, code} = 24'h0;
        en = 1'b1;
        {mr_n, undervoltage_lockout, boot, sdone} = 4'hf;
        sreboot = 1'b0;
        bad_count = 0;
        total_checks = 0;
        low_len = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_read(8'h55, 8'h00);
        reg_read(8'h4d, 8'h01);
        reg_write(8'h4d, 8'hff);
        reg_read(8'h4d, 8'h0f);
        reg_write(8'h10, 8'haa);
        reg_read(8'h10, 8'h00);
        code = 8'($urandom_range(7));
        reg_write(8'h4d, 8'h09);
        reg_write(8'h55, 8'h20 | code);
        reg_read(8'h55, 8'h20 | code);
        krun <= 1'b1;
        repeat (300) @(posedge clk);
        seq_rst <= 1'b1;
        repeat (5) @(posedge clk);
        seq_rst <= 1'b0;
        wait_for(1'b1, 1'b1);
        repeat (100) @(posedge clk);
        ev_q.push_back(2'b00);
        krun <= 1'b0;
        wait_for(1'b0, 1'b0);
        repeat (50) @(posedge clk);
        krun <= 1'b1;
        wait_for(1'b0, 1'b1);
        repeat (30) @(posedge clk);
        reg_write(8'h55, 8'he0 | code);
        ev_q.push_back(2'b11);
        krun <= 1'b0;
        wait_for(1'b0, 1'b0);
        wait_for(1'b0, 1'b1);
        @(posedge clk);
        chk("state", 8'h01, {5'h0, state});
        krun <= 1'b1;
        repeat (30) @(posedge clk);
        chk("state", 8'h02, {5'h0, state});
        reg_write(8'h4d, 8'h01);
        seq_rst <= 1'b1;
        repeat (6) @(posedge clk);
        chk("state", 8'h00, {5'h0, state});
        chk("fault", 8'h01, {7'h0, fault_n});
        seq_rst <= 1'b0;
        wait_for(1'b1, 1'b1);
        repeat (200) @(posedge clk);
        ev_q.push_back(2'b11);
        krun <= 1'b0;
        wait_for(1'b0, 1'b0);
        wait_for(1'b1, 1'b1);
        krun <= 1'b1;
        en <= 1'b0;
        repeat (8) @(posedge clk);
        chk("state", 8'h00, {5'h0, state});
        en <= 1'b1;
        wait_for(1'b1, 1'b1);
        reg_write(8'h55, 8'h00);
        repeat (4) @(posedge clk);
        chk("state", 8'h00, {5'h0, state});
        mr_n <= 1'b0;
        wait_for(1'b1, 1'b0);
        mr_n <= 1'b1;
        wait_for(1'b1, 1'b1);
        sreboot <= 1'b1;
        @(posedge clk);
        sreboot <= 1'b0;
        wait_for(1'b1, 1'b0);
        wait_for(1'b1, 1'b1);
        give_verdict();
    end
endmodule
